// ==== shared/core_regs_pkg.sv ====
`default_nettype none
package core_regs_pkg;

	// ==========================================================
	// Widths.
	localparam int DATA_W = 16;
	localparam int BYTE_W = 8;
	localparam int LONG_W = 32;
	localparam int ADDR20_W = 20;

	// ==========================================================
	// Register byte offsets on the APB slave, one aligned word each.
	localparam logic [7:0] OFS_DATA_0 = 8'h00;
	localparam logic [7:0] OFS_DATA_1 = 8'h04;
	localparam logic [7:0] OFS_DATA_2 = 8'h08;
	localparam logic [7:0] OFS_DATA_3 = 8'h0c;
	localparam logic [7:0] OFS_ADDR_0 = 8'h10;
	localparam logic [7:0] OFS_ADDR_1 = 8'h14;
	localparam logic [7:0] OFS_FRAME = 8'h18;
	localparam logic [7:0] OFS_STATIC = 8'h1c;
	localparam logic [7:0] OFS_INTERRUPT_TABLE_BASE = 8'h20;
	localparam logic [7:0] OFS_PC = 8'h24;
	localparam logic [7:0] OFS_USP = 8'h28;
	localparam logic [7:0] OFS_ISP = 8'h2c;
	localparam logic [7:0] OFS_FLAGS = 8'h30;

	// ==========================================================
	// Flag word bit positions of the two selects held here.
	localparam int FLAG_BANK_BIT = 0;
	localparam int FLAG_STACK_BIT = 1;
	localparam logic [1:0] FLAGS_RESET = 2'h0;

	// ==========================================================
	// Register selectors used by the core port.
	typedef enum logic [3:0] {
		SEL_DATA_0, SEL_DATA_1, SEL_DATA_2, SEL_DATA_3,
		SEL_ADDR_0, SEL_ADDR_1, SEL_FRAME, SEL_STATIC,
		SEL_INTERRUPT_TABLE_BASE, SEL_PC, SEL_SP, SEL_NONE
	} reg_sel_e;

	// Access sizes on the core port.
	typedef enum logic [1:0] {
		SIZE_LOW_BYTE, SIZE_HIGH_BYTE, SIZE_WORD, SIZE_LONG
	} acc_size_e;

	// Slave wait-state handling of the APB port.
	typedef enum logic {
		APB_IDLE, APB_DONE
	} apb_state_e;

	localparam logic [15:0] WORD_ZERO = 16'h0000;
	localparam logic [19:0] ADDR20_ZERO = 20'h00000;

endpackage : core_regs_pkg
`default_nettype wire

// ==== rtl/byte_merge.sv ====
`timescale 1ns/1ps
`default_nettype none
// Merges a write into a 16-bit word, keeping the half that is not written.
module byte_merge (
	input  wire logic [15:0]                 old_word,
	input  wire logic [15:0]                 new_data,
	input  wire core_regs_pkg::acc_size_e    size,
	output logic      [15:0]                 merged
);

	// ==========================================================
	// Byte lane selection.
	// A byte write always takes its value from the low byte of the data.
	assign merged = (size == core_regs_pkg::SIZE_LOW_BYTE)  ? {old_word[15:8], new_data[7:0]} :
			(size == core_regs_pkg::SIZE_HIGH_BYTE) ? {new_data[7:0], old_word[7:0]} :
			new_data;

endmodule : byte_merge
`default_nettype wire

// ==== rtl/bank_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
// One bank of the data and address registers.
module bank_regs (
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  wire logic        clk_en,
	input  wire logic [5:0]  wr_en,
	input  wire logic [15:0] wr_lo,
	input  wire logic [15:0] wr_hi,
	output logic      [95:0] bank_flat
);

	logic [15:0] word_reg [0:5];

	// ==========================================================
	// Storage; index 0..3 data, 4..5 address.
	// The high data lane feeds data 2, 3 and address 1 so that long writes land in one cycle.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < 6; i++) word_reg[i] <= core_regs_pkg::WORD_ZERO;
		end else if (clk_en) begin
			for (int i = 0; i < 6; i++) begin
				if (wr_en[i]) word_reg[i] <= (i == 2 || i == 3 || i == 5) ? wr_hi : wr_lo;
			end
		end
	end

	assign bank_flat = {word_reg[5], word_reg[4], word_reg[3], word_reg[2], word_reg[1], word_reg[0]};

endmodule : bank_regs
`default_nettype wire

// ==== rtl/cpu_core_register_set.sv ====
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Four 16-bit general data registers.
// - Data 0 and 1 split into bytes.
// - Data 2:0 and 3:1 form longs.
// - Two 16-bit address registers, also operands.
// - Address 1:0 form a long.
// - 16-bit frame base register.
// - 20-bit interrupt table base register.
// - 20-bit program counter, next instruction.
// - Separate 16-bit user and interrupt stacks.
// - Stack select flag picks active stack.
// - 16-bit static base register.
// - Stack flag 0 interrupt; cleared on acknowledge.
// - Bank flag selects register bank 0/1.
module cpu_core_register_set (
	input  wire logic                      sys_clk,
	input  wire logic                      reset_n,
	input  wire logic                      clk_en,
	// Core write port.
	input  wire logic                      wr_valid,
	input  wire core_regs_pkg::reg_sel_e   wr_sel,
	input  wire core_regs_pkg::acc_size_e  wr_size,
	input  wire logic [31:0]               wr_data,
	// Core read port, registered.
	input  wire core_regs_pkg::reg_sel_e   rd_sel,
	input  wire core_regs_pkg::acc_size_e  rd_size,
	output logic      [31:0]               rd_data,
	// Program counter control.
	input  wire logic                      pc_advance,
	input  wire logic [19:0]               pc_step,
	// Flag control.
	input  wire logic                      flag_wr,
	input  wire logic [1:0]                flag_wr_data,
	input  wire logic                      int_ack,
	output logic                           bank_sel,
	output logic                           stack_sel,
	output logic      [15:0]               active_sp,
	output logic      [19:0]               program_counter,
	output logic      [19:0]               interrupt_table_base,
	// APB slave.
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [7:0]                paddr,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr
);

	// ==========================================================
	// State.
	logic [15:0] frame_base_reg;
	logic [15:0] static_base_reg;
	logic [19:0] interrupt_table_base_reg;
	logic [19:0] pc_reg;
	logic [15:0] usp_reg;
	logic [15:0] isp_reg;
	logic        bank_reg;
	logic        stack_reg;
	logic [31:0] rd_data_reg;
	logic [31:0] prdata_reg;
	logic        pready_reg;
	logic        pslverr_reg;
	logic [95:0] bank0_flat;
	logic [95:0] bank1_flat;
	core_regs_pkg::apb_state_e apb_reg;

	// ==========================================================
	// Helper functions.
	function automatic logic [15:0] pick(input logic [95:0] f, input int idx);
		pick = f[idx*16 +: 16];
	endfunction : pick

	function automatic logic [31:0] zext20(input logic [19:0] v);
		zext20 = {12'h000, v};
	endfunction : zext20

	// ==========================================================
	// APB decode; a write takes effect in the access phase only.
	wire        apb_access = psel && penable && (apb_reg == core_regs_pkg::APB_IDLE);
	wire        apb_wr     = apb_access && pwrite;
	wire [1:0]  flags_now  = {stack_reg, bank_reg};
	wire        addr_ok    = (paddr[1:0] == 2'h0) && (paddr <= core_regs_pkg::OFS_FLAGS);

	// Software bus writes take priority over core writes in the same cycle.
	wire        apb_wr_ok  = apb_wr && addr_ok;
	wire [3:0]  apb_idx    = paddr[5:2];
	wire        core_wr    = wr_valid && !apb_wr_ok;

	// Bus target translated to a selector so one write path serves both ports.
	// Stack and flag slots map to no selector, so a bus write there never reaches the active pointer.
	wire core_regs_pkg::reg_sel_e eff_sel =
		apb_wr_ok ? ((apb_idx >= core_regs_pkg::OFS_USP[5:2]) ? core_regs_pkg::SEL_NONE
			: core_regs_pkg::reg_sel_e'(apb_idx)) :
		core_wr ? wr_sel : core_regs_pkg::SEL_NONE;
	wire core_regs_pkg::acc_size_e eff_size = apb_wr_ok ? core_regs_pkg::SIZE_WORD : wr_size;
	wire [31:0] eff_data = apb_wr_ok ? pwdata : wr_data;

	// Bus writes to the stack slots address a specific pointer, not the active one.
	wire apb_usp_wr = apb_wr_ok && (paddr == core_regs_pkg::OFS_USP);
	wire apb_isp_wr = apb_wr_ok && (paddr == core_regs_pkg::OFS_ISP);
	wire apb_flag_wr = apb_wr_ok && (paddr == core_regs_pkg::OFS_FLAGS);

	// ==========================================================
	// Bank register write lanes.
	wire [95:0] act_flat = bank_reg ? bank1_flat : bank0_flat;
	wire is_long = (eff_size == core_regs_pkg::SIZE_LONG);
	wire [15:0] merged;
	wire [15:0] merge_old = (eff_sel == core_regs_pkg::SEL_DATA_1) ? pick(act_flat, 1)
			: pick(act_flat, 0);

	byte_merge u_merge (
		.old_word (merge_old),
		.new_data (eff_data[15:0]),
		.size     (eff_size),
		.merged   (merged)
	);

	// Long writes to data 0/1 also load data 2/3; to address 0 also loads address 1.
	wire [5:0] wr_vec = {
		(eff_sel == core_regs_pkg::SEL_ADDR_1) || (eff_sel == core_regs_pkg::SEL_ADDR_0 && is_long),
		(eff_sel == core_regs_pkg::SEL_ADDR_0),
		(eff_sel == core_regs_pkg::SEL_DATA_3) || (eff_sel == core_regs_pkg::SEL_DATA_1 && is_long),
		(eff_sel == core_regs_pkg::SEL_DATA_2) || (eff_sel == core_regs_pkg::SEL_DATA_0 && is_long),
		(eff_sel == core_regs_pkg::SEL_DATA_1),
		(eff_sel == core_regs_pkg::SEL_DATA_0)
	};
	wire single_hi = (eff_sel == core_regs_pkg::SEL_DATA_2) || (eff_sel == core_regs_pkg::SEL_DATA_3)
			|| (eff_sel == core_regs_pkg::SEL_ADDR_1);
	wire [15:0] lane_lo = merged;
	wire [15:0] lane_hi = single_hi ? eff_data[15:0] : eff_data[31:16];

	bank_regs u_bank0 (
		.sys_clk   (sys_clk),
		.reset_n   (reset_n),
		.clk_en    (clk_en),
		.wr_en     (bank_reg ? 6'h00 : wr_vec),
		.wr_lo     (lane_lo),
		.wr_hi     (lane_hi),
		.bank_flat (bank0_flat)
	);

	bank_regs u_bank1 (
		.sys_clk   (sys_clk),
		.reset_n   (reset_n),
		.clk_en    (clk_en),
		.wr_en     (bank_reg ? wr_vec : 6'h00),
		.wr_lo     (lane_lo),
		.wr_hi     (lane_hi),
		.bank_flat (bank1_flat)
	);

	// ==========================================================
	// Core read mux.
	wire [15:0] sp_now = stack_reg ? usp_reg : isp_reg;
	wire [15:0] rd_word =
		(rd_sel == core_regs_pkg::SEL_DATA_0) ? pick(act_flat, 0) :
		(rd_sel == core_regs_pkg::SEL_DATA_1) ? pick(act_flat, 1) :
		(rd_sel == core_regs_pkg::SEL_DATA_2) ? pick(act_flat, 2) :
		(rd_sel == core_regs_pkg::SEL_DATA_3) ? pick(act_flat, 3) :
		(rd_sel == core_regs_pkg::SEL_ADDR_0) ? pick(act_flat, 4) :
		(rd_sel == core_regs_pkg::SEL_ADDR_1) ? pick(act_flat, 5) :
		(rd_sel == core_regs_pkg::SEL_FRAME)  ? frame_base_reg :
		(rd_sel == core_regs_pkg::SEL_STATIC) ? static_base_reg :
		(rd_sel == core_regs_pkg::SEL_SP)     ? sp_now : core_regs_pkg::WORD_ZERO;
	wire [15:0] rd_long_hi =
		(rd_sel == core_regs_pkg::SEL_DATA_0) ? pick(act_flat, 2) :
		(rd_sel == core_regs_pkg::SEL_DATA_1) ? pick(act_flat, 3) :
		(rd_sel == core_regs_pkg::SEL_ADDR_0) ? pick(act_flat, 5) : core_regs_pkg::WORD_ZERO;
	wire [31:0] rd_next =
		(rd_sel == core_regs_pkg::SEL_INTERRUPT_TABLE_BASE) ? zext20(interrupt_table_base_reg) :
		(rd_sel == core_regs_pkg::SEL_PC)   ? zext20(pc_reg) :
		(rd_size == core_regs_pkg::SIZE_LONG)      ? {rd_long_hi, rd_word} :
		(rd_size == core_regs_pkg::SIZE_HIGH_BYTE) ? {24'h000000, rd_word[15:8]} :
		(rd_size == core_regs_pkg::SIZE_LOW_BYTE)  ? {24'h000000, rd_word[7:0]} :
		{16'h0000, rd_word};

	// ==========================================================
	// APB read mux; data and address slots show the active bank.
	wire [31:0] apb_rd =
		(paddr == core_regs_pkg::OFS_DATA_0) ? {16'h0000, pick(act_flat, 0)} :
		(paddr == core_regs_pkg::OFS_DATA_1) ? {16'h0000, pick(act_flat, 1)} :
		(paddr == core_regs_pkg::OFS_DATA_2) ? {16'h0000, pick(act_flat, 2)} :
		(paddr == core_regs_pkg::OFS_DATA_3) ? {16'h0000, pick(act_flat, 3)} :
		(paddr == core_regs_pkg::OFS_ADDR_0) ? {16'h0000, pick(act_flat, 4)} :
		(paddr == core_regs_pkg::OFS_ADDR_1) ? {16'h0000, pick(act_flat, 5)} :
		(paddr == core_regs_pkg::OFS_FRAME)  ? {16'h0000, frame_base_reg} :
		(paddr == core_regs_pkg::OFS_STATIC) ? {16'h0000, static_base_reg} :
		(paddr == core_regs_pkg::OFS_INTERRUPT_TABLE_BASE)   ? zext20(interrupt_table_base_reg) :
		(paddr == core_regs_pkg::OFS_PC)     ? zext20(pc_reg) :
		(paddr == core_regs_pkg::OFS_USP)    ? {16'h0000, usp_reg} :
		(paddr == core_regs_pkg::OFS_ISP)    ? {16'h0000, isp_reg} :
		(paddr == core_regs_pkg::OFS_FLAGS)  ? {30'h0, flags_now} : 32'h00000000;

	// ==========================================================
	// Flag next state; an acknowledge beats any write of the stack bit.
	wire [1:0] flag_src = apb_flag_wr ? pwdata[1:0] : flag_wr_data;
	wire       flag_any = apb_flag_wr || flag_wr;
	wire bank_next  = flag_any ? flag_src[core_regs_pkg::FLAG_BANK_BIT] : bank_reg;
	wire stack_next = int_ack ? 1'b0
			: (flag_any ? flag_src[core_regs_pkg::FLAG_STACK_BIT] : stack_reg);

	// Core stack writes reach whichever pointer is active.
	wire sp_core_wr = (eff_sel == core_regs_pkg::SEL_SP);
	wire [19:0] pc_next = (eff_sel == core_regs_pkg::SEL_PC) ? eff_data[19:0]
			: (pc_advance ? pc_reg + pc_step : pc_reg);

	// ==========================================================
	// Dedicated registers.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			frame_base_reg  <= core_regs_pkg::WORD_ZERO;
			static_base_reg <= core_regs_pkg::WORD_ZERO;
			interrupt_table_base_reg        <= core_regs_pkg::ADDR20_ZERO;
			pc_reg          <= core_regs_pkg::ADDR20_ZERO;
			usp_reg         <= core_regs_pkg::WORD_ZERO;
			isp_reg         <= core_regs_pkg::WORD_ZERO;
			bank_reg        <= core_regs_pkg::FLAGS_RESET[core_regs_pkg::FLAG_BANK_BIT];
			stack_reg       <= core_regs_pkg::FLAGS_RESET[core_regs_pkg::FLAG_STACK_BIT];
		end else if (clk_en) begin
			if (eff_sel == core_regs_pkg::SEL_FRAME)  frame_base_reg  <= eff_data[15:0];
			if (eff_sel == core_regs_pkg::SEL_STATIC) static_base_reg <= eff_data[15:0];
			if (eff_sel == core_regs_pkg::SEL_INTERRUPT_TABLE_BASE)   interrupt_table_base_reg <= eff_data[19:0];
			pc_reg <= pc_next;
			if (apb_usp_wr || (sp_core_wr && stack_reg))  usp_reg <= eff_data[15:0];
			if (apb_isp_wr || (sp_core_wr && !stack_reg)) isp_reg <= eff_data[15:0];
			bank_reg  <= bank_next;
			stack_reg <= stack_next;
		end
	end

	// ==========================================================
	// Output and bus answer registers; every bus access answers one cycle after access begins.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_data_reg <= 32'h00000000;
			prdata_reg  <= 32'h00000000;
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			apb_reg     <= core_regs_pkg::APB_IDLE;
		end else if (clk_en) begin
			rd_data_reg <= rd_next;
			pready_reg  <= apb_access;
			pslverr_reg <= apb_access && !addr_ok;
			prdata_reg  <= (apb_access && !pwrite && addr_ok) ? apb_rd : 32'h00000000;
			case (apb_reg)
				core_regs_pkg::APB_IDLE: apb_reg <= apb_access ? core_regs_pkg::APB_DONE
						: core_regs_pkg::APB_IDLE;
				core_regs_pkg::APB_DONE: apb_reg <= core_regs_pkg::APB_IDLE;
				default: apb_reg <= core_regs_pkg::APB_IDLE;
			endcase
		end
	end

	// Outputs straight from flip-flops, except active_sp, a mux of the two stack pointers.
	assign rd_data              = rd_data_reg;
	assign prdata               = prdata_reg;
	assign pready               = pready_reg;
	assign pslverr              = pslverr_reg;
	assign bank_sel             = bank_reg;
	assign stack_sel            = stack_reg;
	assign program_counter      = pc_reg;
	assign interrupt_table_base = interrupt_table_base_reg;
	assign active_sp            = stack_reg ? usp_reg : isp_reg;

endmodule : cpu_core_register_set
`default_nettype wire

// ==== test/core_regs_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Port checker of the register set.
module core_regs_checker (
	input wire logic                     sys_clk,
	input wire logic                     reset_n,
	input wire logic                     clk_en,
	input wire logic                     wr_valid,
	input wire core_regs_pkg::reg_sel_e  wr_sel,
	input wire logic                     pc_advance,
	input wire logic [19:0]              pc_step,
	input wire logic                     flag_wr,
	input wire logic [1:0]               flag_wr_data,
	input wire logic                     int_ack,
	input wire logic                     bank_sel,
	input wire logic                     stack_sel,
	input wire logic [19:0]              program_counter,
	input wire logic [19:0]              interrupt_table_base,
	input wire logic                     psel,
	input wire logic                     penable,
	input wire logic                     pwrite,
	input wire logic [7:0]               paddr,
	input wire logic [31:0]              pwdata,
	input wire logic [31:0]              prdata,
	input wire logic                     pready,
	input wire logic                     pslverr
);
	// Bus access decode; an idle slave takes a request only while pready is low.
	wire logic take    = psel & penable & ~pready & clk_en;
	wire logic bus_wr  = take & pwrite;
	wire logic bad_adr = (paddr[1:0] != 2'h0) | (paddr > 8'h30);
	wire logic flag_bw = bus_wr & (paddr == core_regs_pkg::OFS_FLAGS);
	wire logic pc_wr   = (wr_valid & (wr_sel == core_regs_pkg::SEL_PC))
		| (bus_wr & (paddr == core_regs_pkg::OFS_PC));

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	AST_APB_READY: assert property (take |=> pready)
		else $error("bus access not answered one cycle later");
	AST_READY_ONE: assert property (pready && clk_en |=> !pready)
		else $error("ready stood longer than one cycle");
	AST_ERR_WITH_READY: assert property (pslverr |-> pready)
		else $error("error flag without ready");
	AST_REFUSE: assert property (take && bad_adr |=> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	AST_INTERRUPT_TABLE_BASE: assert property (bus_wr && paddr == core_regs_pkg::OFS_INTERRUPT_TABLE_BASE
		|=> interrupt_table_base == $past(pwdata[19:0]))
		else $error("table base not loaded with 20 bits");
	AST_PC_STEP: assert property (clk_en && pc_advance && !pc_wr
		|=> program_counter == $past(program_counter) + $past(pc_step))
		else $error("program counter did not advance by step");
	AST_ACK: assert property (clk_en && int_ack |=> !stack_sel)
		else $error("acknowledge did not pick interrupt stack");
	AST_BANK: assert property (clk_en && flag_wr && !flag_bw
		|=> bank_sel == $past(flag_wr_data[0]))
		else $error("bank select not loaded");
	AST_STACK_HOLD: assert property (clk_en && !int_ack && !flag_wr && !flag_bw
		|=> $stable(stack_sel))
		else $error("stack select changed with no cause");
endmodule : core_regs_checker

bind cpu_core_register_set core_regs_checker core_regs_checker_i (.sys_clk, .reset_n,
	.clk_en, .wr_valid, .wr_sel, .pc_advance, .pc_step, .flag_wr, .flag_wr_data,
	.int_ack, .bank_sel, .stack_sel, .program_counter, .interrupt_table_base, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
`default_nettype wire

// ==== test/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
	// ==========================================================
	// Ports and bench state.
	logic                      sys_clk, reset_n, clk_en, wr_valid, pc_advance;
	logic                      flag_wr, int_ack, bank_sel, stack_sel, psel, penable;
	logic                      pwrite, pready, pslverr, rd_chk, chk_d;
	core_regs_pkg::reg_sel_e   wr_sel, rd_sel;
	core_regs_pkg::acc_size_e  wr_size, rd_size;
	logic [31:0]               wr_data, rd_data, pwdata, prdata, v, w;
	logic [19:0]               pc_step, program_counter, interrupt_table_base, st, pc_x;
	logic [15:0]               active_sp;
	logic [1:0]                flag_wr_data;
	logic [7:0]                paddr, lo;
	logic [33:0]               e;
	logic [33:0]               apb_q[$];
	logic [31:0]               rd_q[$];
	logic [31:0]               ev[13];
	int                        n_mismatch, tests_run, cyc, seed, i;

	cpu_core_register_set cpu_core_register_set_i (.sys_clk, .reset_n, .clk_en, .wr_valid,
		.wr_sel, .wr_size, .wr_data, .rd_sel, .rd_size, .rd_data, .pc_advance, .pc_step,
		.flag_wr, .flag_wr_data, .int_ack, .bank_sel, .stack_sel, .active_sp,
		.program_counter, .interrupt_table_base, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr);

	// Free-running 100 MHz clock.
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// ==========================================================
	// Comparison and closing.
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : cmp

	task automatic stop_test;
		$display("compared %0d, mismatched %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : stop_test

	// Result watcher: takes the oldest note whenever an answer shows, and cuts hangs short.
	always @(posedge sys_clk) begin
		if (pready === 1'b1) begin
			e = apb_q.pop_front();
			if (e[33]) cmp(prdata, e[31:0], "bus read");
			cmp({31'h0, pslverr}, {31'h0, e[32]}, "bus error flag");
		end
		if (chk_d) cmp(rd_data, rd_q.pop_front(), "core read");
		chk_d <= rd_chk;
		cyc++;
		if (cyc > 20000) begin
			n_mismatch++;
			stop_test();
		end
	end

	// ==========================================================
	// Drivers; each leaves a clock edge free before its next request.
	task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] d,
		input logic [31:0] x, input logic err);
		apb_q.push_back({~wr, err, x});
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1 && cyc < 20000);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask : apb

	task automatic cw(input core_regs_pkg::reg_sel_e s, input core_regs_pkg::acc_size_e z,
		input logic [31:0] d);
		wr_valid <= 1'b1;
		wr_sel <= s;
		wr_size <= z;
		wr_data <= d;
		@(posedge sys_clk);
		wr_valid <= 1'b0;
		@(posedge sys_clk);
	endtask : cw

	task automatic cr(input core_regs_pkg::reg_sel_e s, input core_regs_pkg::acc_size_e z,
		input logic [31:0] x);
		rd_q.push_back(x);
		rd_sel <= s;
		rd_size <= z;
		rd_chk <= 1'b1;
		@(posedge sys_clk);
		rd_chk <= 1'b0;
		@(posedge sys_clk);
	endtask : cr

	task automatic flags(input logic [1:0] f, input logic ack);
		flag_wr <= 1'b1;
		flag_wr_data <= f;
		int_ack <= ack;
		@(posedge sys_clk);
		flag_wr <= 1'b0;
		int_ack <= 1'b0;
		@(posedge sys_clk);
	endtask : flags

	// ==========================================================
	// Main sequence.
	initial begin
		seed = 32'hfc27;
		{reset_n, wr_valid, pc_advance, flag_wr, int_ack, psel, penable, pwrite} = 8'h00;
		{rd_chk, chk_d, flag_wr_data, paddr, pwdata, wr_data, pc_step} = 0;
		clk_en = 1'b1;
		wr_sel = core_regs_pkg::SEL_NONE;
		rd_sel = core_regs_pkg::SEL_NONE;
		wr_size = core_regs_pkg::SIZE_WORD;
		rd_size = core_regs_pkg::SIZE_WORD;
		repeat (3) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		for (i = 0; i <= 12; i++) apb(8'(i * 4), 1'b0, 0, 0, 1'b0);
		cmp({31'h0, stack_sel}, 0, "stack select after reset");
		$display("reset values done");
		// Each register keeps exactly its own width; a 20-bit one keeps 20 bits.
		for (i = 0; i < 12; i++) begin
			v = $random(seed);
			ev[i] = (i == 8 || i == 9) ? {12'h0, v[19:0]} : {16'h0, v[15:0]};
			apb(8'(i * 4), 1'b1, v, 0, 1'b0);
		end
		for (i = 0; i < 12; i++) apb(8'(i * 4), 1'b0, 0, ev[i], 1'b0);
		cmp({12'h0, program_counter}, ev[9], "program counter out");
		cmp({12'h0, interrupt_table_base}, ev[8], "table base out");
		apb(8'h34, 1'b0, 0, 0, 1'b1);
		apb(8'h02, 1'b1, 32'hffff, 0, 1'b1);
		apb(8'h00, 1'b0, 0, ev[0], 1'b0);
		$display("word access done");
		for (i = 0; i < 2; i++) begin
			v = $random(seed);
			w = $random(seed);
			cw(core_regs_pkg::reg_sel_e'(i), core_regs_pkg::SIZE_WORD, v);
			cw(core_regs_pkg::reg_sel_e'(i), core_regs_pkg::SIZE_HIGH_BYTE, w);
			cr(core_regs_pkg::reg_sel_e'(i), core_regs_pkg::SIZE_WORD, {16'h0, w[7:0], v[7:0]});
			cw(core_regs_pkg::reg_sel_e'(i), core_regs_pkg::SIZE_LOW_BYTE, {24'h0, w[15:8]});
			cr(core_regs_pkg::reg_sel_e'(i), core_regs_pkg::SIZE_WORD, {16'h0, w[7:0], w[15:8]});
			cr(core_regs_pkg::reg_sel_e'(i), core_regs_pkg::SIZE_HIGH_BYTE, {24'h0, w[7:0]});
		end
		$display("byte access done");
		for (i = 0; i < 3; i++) begin
			v = $random(seed);
			ev[i] = v;
			lo = (i == 2) ? 8'h10 : 8'(i * 4);
			cw((i == 2) ? core_regs_pkg::SEL_ADDR_0 : core_regs_pkg::reg_sel_e'(i),
				core_regs_pkg::SIZE_LONG, v);
			apb(lo, 1'b0, 0, {16'h0, v[15:0]}, 1'b0);
			apb(lo + ((i == 2) ? 8'h4 : 8'h8), 1'b0, 0, {16'h0, v[31:16]}, 1'b0);
		end
		cr(core_regs_pkg::SEL_ADDR_0, core_regs_pkg::SIZE_LONG, v);
		$display("long access done");
		w = $random(seed);
		flags(2'b01, 1'b0);
		cmp({31'h0, bank_sel}, 1, "bank select set");
		apb(8'h04, 1'b1, w, 0, 1'b0);
		apb(8'h04, 1'b0, 0, {16'h0, w[15:0]}, 1'b0);
		apb(8'h30, 1'b1, 0, 0, 1'b0);
		cmp({31'h0, bank_sel}, 0, "bank select cleared");
		apb(8'h04, 1'b0, 0, {16'h0, ev[1][15:0]}, 1'b0);
		$display("bank switch done");
		apb(8'h30, 1'b1, 32'h2, 0, 1'b0);
		cmp({31'h0, stack_sel}, 1, "user stack chosen");
		cmp({16'h0, active_sp}, ev[10], "user pointer active");
		cw(core_regs_pkg::SEL_SP, core_regs_pkg::SIZE_WORD, w);
		apb(8'h28, 1'b0, 0, {16'h0, w[15:0]}, 1'b0);
		flags(2'b10, 1'b1);
		cmp({31'h0, stack_sel}, 0, "acknowledge picks interrupt stack");
		cmp({16'h0, active_sp}, ev[11], "interrupt pointer active");
		// A bus write to the user pointer must leave the active interrupt pointer alone.
		apb(8'h28, 1'b1, w, 0, 1'b0);
		apb(8'h2c, 1'b0, 0, ev[11], 1'b0);
		$display("stack select done");
		pc_x = ev[9][19:0];
		for (i = 0; i < 8; i++) begin
			st = 20'($random(seed));
			pc_step <= st;
			pc_advance <= 1'b1;
			pc_x = pc_x + st;
			@(posedge sys_clk);
		end
		// Two frozen edges with the advance still asked for must not move the counter.
		clk_en <= 1'b0;
		repeat (2) @(posedge sys_clk);
		clk_en <= 1'b1;
		pc_advance <= 1'b0;
		@(posedge sys_clk);
		cmp({12'h0, program_counter}, {12'h0, pc_x}, "program counter steps");
		$display("program counter done");
		stop_test();
	end
endmodule : tb
`default_nettype wire
